/* File: design/perf_event_pkg.sv */
// Constants, field layouts and types for the event-selection decoder
// How it works
// - Code 24H mask 24H counts instruction fetches missing the second-level cache.
// - Code 24H: mask 27H counts demand misses, E7H all demand requests.
// - Code 24H mask E4H counts all code requests to the second-level cache.
// - Code 24H: 50H prefetch hits, 30H prefetch misses, F8H all prefetches.
// - Code 24H: 3FH counts every miss, FFH counts every request.
// - Code 27H mask 50H counts unrejected writebacks hitting the second-level cache.
// - Code 2EH: 4FH last-level references, 41H last-level misses.
// - Code 3CH mask 00H counts core cycles while the thread is not halted.
// - Code 3CH mask 01H counts 100 MHz reference ticks while not halted.
// - Code 48H mask 01H adds pending first-level misses; counter 2 only.
// - Threshold 1 with edge counts inactive-to-active transitions, not cycles.
// - Code 49H: 01H walks, 02H/04H/0EH completed walks, 10H walker busy.
// - Code 49H: 20H/40H/60H translation second-level hits, 80H directory misses.
// - Code 4CH: loads hitting software (01H) or hardware (02H) prefetch fill buffers.
// - Code 51H mask 01H counts lines filled into the first-level data cache.
// - Code 58H: 01H/02H eliminated, 04H/08H not eliminated moves.
// - Code 5CH: ring 0 (01H) or rings 1-3 (02H) unhalted cycles; edge counts transitions.
// - Code 5EH mask 01H counts cycles with an empty reservation station.
// - Code 60H adds outstanding data (01H), code (02H), ownership (04H) reads.
// - Code 60H counts only while one hardware thread runs per core.
package perf_event_pkg;

  typedef logic [3:0]  count_type;
  typedef logic [7:0]  byte_type;
  typedef logic [31:0] word_type;

  // Register byte addresses
  localparam byte_type ADDR_SELECT = 8'h00;
  localparam byte_type ADDR_COUNT  = 8'h04;
  localparam byte_type ADDR_STATUS = 8'h08;

  // Selection register layout
  typedef struct packed {
    logic [7:0] threshold;
    logic       enable;
    logic [3:0] reserved;
    logic       edgeMode;
    logic [1:0] counterIndex;
    logic [7:0] unitMask;
    logic [7:0] eventCode;
  } select_type;

  localparam word_type SELECT_WRITE_MASK = 32'hFF87_FFFF;
  localparam word_type SELECT_RESET      = 32'h0000_0000;
  localparam word_type COUNT_RESET       = 32'h0000_0000;

  // Status register bit positions
  localparam int STAT_DEFINED = 0;
  localparam int STAT_OFFCORE = 1;
  localparam int STAT_HALTED  = 2;

  // Event codes
  localparam byte_type EV_L2_REQ     = 8'h24;
  localparam byte_type EV_WB_HIT     = 8'h27;
  localparam byte_type EV_LLC        = 8'h2E;
  localparam byte_type EV_UNHALTED   = 8'h3C;
  localparam byte_type EV_PEND_MISS  = 8'h48;
  localparam byte_type EV_STORE_XLAT = 8'h49;
  localparam byte_type EV_LOAD_PF    = 8'h4C;
  localparam byte_type EV_LINE_FILL  = 8'h51;
  localparam byte_type EV_MOVE_ELIM  = 8'h58;
  localparam byte_type EV_RING       = 8'h5C;
  localparam byte_type EV_SCHED_IDLE = 8'h5E;
  localparam byte_type EV_OFFCORE    = 8'h60;

  // Only counter 2 may take the pending-miss event
  localparam logic [1:0] PEND_MISS_COUNTER = 2'h2;

  // Second-level request lines: 0 data miss, 1 data hit, 2 ownership miss,
  // 3 ownership hit, 4 code miss, 5 code hit, 6 prefetch miss, 7 prefetch hit
  localparam byte_type L2_CODE_MISS   = 8'h10;
  localparam byte_type L2_DEMAND_MISS = 8'h15;
  localparam byte_type L2_DEMAND_ALL  = 8'h3F;
  localparam byte_type L2_CODE_ALL    = 8'h30;
  localparam byte_type L2_PF_HIT      = 8'h80;
  localparam byte_type L2_PF_MISS     = 8'h40;
  localparam byte_type L2_PF_ALL      = 8'hC0;
  localparam byte_type L2_ALL_MISS    = 8'h55;
  localparam byte_type L2_ALL         = 8'hFF;

  // Store translation lines: 0 walk, 1-3 done 4K/2M/1G, 4 busy,
  // 5 hit 4K, 6 hit 2M, 7 directory-cache miss
  localparam byte_type XL_WALK     = 8'h01;
  localparam byte_type XL_DONE_4K  = 8'h02;
  localparam byte_type XL_DONE_2M  = 8'h04;
  localparam byte_type XL_DONE_ALL = 8'h0E;
  localparam byte_type XL_BUSY     = 8'h10;
  localparam byte_type XL_HIT_4K   = 8'h20;
  localparam byte_type XL_HIT_2M   = 8'h40;
  localparam byte_type XL_HIT_ALL  = 8'h60;
  localparam byte_type XL_DIR_MISS = 8'h80;

  localparam logic [1:0] RING_ZERO = 2'h0;
  localparam count_type  COUNT_ZERO = 4'h0;
  localparam count_type  COUNT_ONE  = 4'h1;

endpackage

/* File: design/perf_step_if.sv */
// Carrier between decoder, qualifier and accumulator
`timescale 1ns/1ps
interface perf_step_if;
  import perf_event_pkg::*;
  count_type  eventCount;
  logic       active;
  logic [7:0] threshold;
  logic       edgeMode;
  count_type  step;

  modport decode  (output eventCount, output active, output threshold, output edgeMode);
  modport qualify (input eventCount, input active, input threshold, input edgeMode,
                   output step);
  modport accum   (input step);
endinterface

/* File: design/count_qualifier.sv */
// Threshold and edge qualification of the per-cycle event count
`timescale 1ns/1ps
module count_qualifier (
  input  wire logic    sys_clk,
  input  wire logic    arst_n,
  perf_step_if.qualify link
);
  import perf_event_pkg::*;

  typedef struct packed {
    logic prevHit;
  } qual_state_type;

  qual_state_type st_r;
  qual_state_type st_nxt;
  logic           hit;

  // Condition seen this cycle; zero threshold means any nonzero count
  always_comb begin
    st_nxt = st_r;
    if (link.threshold == 8'h00) begin
      hit = (link.eventCount != COUNT_ZERO);
    end else begin
      hit = ({4'h0, link.eventCount} >= link.threshold);
    end
    hit = hit & link.active;
    st_nxt.prevHit = hit;
    if (!link.active) begin
      link.step = COUNT_ZERO;
    end else if (link.edgeMode) begin
      link.step = (hit && !st_r.prevHit) ? COUNT_ONE : COUNT_ZERO;
    end else if (link.threshold != 8'h00) begin
      link.step = hit ? COUNT_ONE : COUNT_ZERO;
    end else begin
      link.step = link.eventCount;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* File: design/count_accumulator.sv */
// Event counter with software load
`timescale 1ns/1ps
module count_accumulator (
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  input  wire logic                       load,
  input  wire perf_event_pkg::word_type   loadValue,
  perf_step_if.accum                      link,
  output perf_event_pkg::word_type        value
);
  import perf_event_pkg::*;

  typedef struct packed {
    word_type count;
  } acc_state_type;

  acc_state_type st_r;
  acc_state_type st_nxt;

  // Software load replaces the step of that cycle; wraps silently
  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.count = loadValue;
    end else begin
      st_nxt.count = st_r.count + {28'h0, link.step};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{count: COUNT_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.count;

endmodule

/* File: design/perf_event_select_decoder.sv */
// Event-selection decoder: register port, event decode and counter
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module perf_event_select_decoder (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  // Register port
  input  wire perf_event_pkg::byte_type  regAddr,
  input  wire perf_event_pkg::word_type  regWrData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output perf_event_pkg::word_type       regRdData,
  // Microarchitectural condition inputs
  input  wire logic [7:0]                secondLevelRequestEvents,
  input  wire logic                      writebackHitEvent,
  input  wire logic                      lastLevelRefEvent,
  input  wire logic                      lastLevelMissEvent,
  input  wire logic                      threadHalted,
  input  wire logic                      referenceClock100mTick,
  input  wire perf_event_pkg::count_type pendingFirstLevelMisses,
  input  wire logic [7:0]                storeTranslationMissEvents,
  input  wire logic [1:0]                prefetchFillBufferHits,
  input  wire logic                      firstLevelLineFillEvent,
  input  wire logic [3:0]                moveEliminationEvents,
  input  wire logic [1:0]                privilegeRing,
  input  wire logic                      reservationStationEmpty,
  input  wire perf_event_pkg::count_type offcoreDataReads,
  input  wire perf_event_pkg::count_type offcoreCodeReads,
  input  wire perf_event_pkg::count_type offcoreOwnershipReads,
  input  wire logic                      multithreading,
  // Counter view
  output perf_event_pkg::word_type       counterValue,
  output logic                           selectionValid
);
  import perf_event_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Number of asserted lines under a mask; all event lines are one per cycle
  function automatic count_type maskCount(input byte_type lines, input byte_type mask);
    count_type n;
    byte_type  hits;
    n = COUNT_ZERO;
    hits = lines & mask;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, hits[i]};
    end
    return n;
  endfunction

  // One-bit condition widened to a count
  function automatic count_type asCount(input logic cond);
    return {3'h0, cond};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    select_type sel;
    word_type   rdData;
    word_type   counterOut;
    logic       valid;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;

  perf_step_if step ();

  count_type  evCount;
  logic       evDefined;
  logic       offcoreOk;
  logic       countLoad;
  word_type   accValue;
  word_type   statusWord;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  // Undecoded pairs leave evDefined low so nothing is counted
  always_comb begin
    evCount   = COUNT_ZERO;
    evDefined = 1'b0;
    offcoreOk = !multithreading;
    unique case (st_r.sel.eventCode)
      EV_L2_REQ: begin
        evDefined = 1'b1;
        case (st_r.sel.unitMask)
          8'h24: evCount = maskCount(secondLevelRequestEvents, L2_CODE_MISS);
          8'h27: evCount = maskCount(secondLevelRequestEvents, L2_DEMAND_MISS);
          8'hE7: evCount = maskCount(secondLevelRequestEvents, L2_DEMAND_ALL);
          8'hE4: evCount = maskCount(secondLevelRequestEvents, L2_CODE_ALL);
          8'h50: evCount = maskCount(secondLevelRequestEvents, L2_PF_HIT);
          8'h30: evCount = maskCount(secondLevelRequestEvents, L2_PF_MISS);
          8'hF8: evCount = maskCount(secondLevelRequestEvents, L2_PF_ALL);
          8'h3F: evCount = maskCount(secondLevelRequestEvents, L2_ALL_MISS);
          8'hFF: evCount = maskCount(secondLevelRequestEvents, L2_ALL);
          default: evDefined = 1'b0;
        endcase
      end
      EV_WB_HIT: begin
        evDefined = (st_r.sel.unitMask == 8'h50);
        evCount   = asCount(writebackHitEvent);
      end
      EV_LLC: begin
        case (st_r.sel.unitMask)
          8'h4F: begin
            evDefined = 1'b1;
            evCount   = asCount(lastLevelRefEvent);
          end
          8'h41: begin
            evDefined = 1'b1;
            evCount   = asCount(lastLevelMissEvent);
          end
          default: evDefined = 1'b0;
        endcase
      end
      EV_UNHALTED: begin
        case (st_r.sel.unitMask)
          8'h00: begin
            evDefined = 1'b1;
            evCount   = asCount(!threadHalted);
          end
          // Tick pulse comes from the reference clock's own domain logic
          8'h01: begin
            evDefined = 1'b1;
            evCount   = asCount(referenceClock100mTick && !threadHalted);
          end
          default: evDefined = 1'b0;
        endcase
      end
      EV_PEND_MISS: begin
        // Other counters see this pair as undefined
        evDefined = (st_r.sel.unitMask == 8'h01)
                    && (st_r.sel.counterIndex == PEND_MISS_COUNTER);
        evCount   = pendingFirstLevelMisses;
      end
      EV_STORE_XLAT: begin
        evDefined = 1'b1;
        case (st_r.sel.unitMask)
          8'h01: evCount = maskCount(storeTranslationMissEvents, XL_WALK);
          8'h02: evCount = maskCount(storeTranslationMissEvents, XL_DONE_4K);
          8'h04: evCount = maskCount(storeTranslationMissEvents, XL_DONE_2M);
          8'h0E: evCount = maskCount(storeTranslationMissEvents, XL_DONE_ALL);
          8'h10: evCount = maskCount(storeTranslationMissEvents, XL_BUSY);
          8'h20: evCount = maskCount(storeTranslationMissEvents, XL_HIT_4K);
          8'h40: evCount = maskCount(storeTranslationMissEvents, XL_HIT_2M);
          8'h60: evCount = maskCount(storeTranslationMissEvents, XL_HIT_ALL);
          8'h80: evCount = maskCount(storeTranslationMissEvents, XL_DIR_MISS);
          default: evDefined = 1'b0;
        endcase
      end
      EV_LOAD_PF: begin
        case (st_r.sel.unitMask)
          8'h01: begin
            evDefined = 1'b1;
            evCount   = asCount(prefetchFillBufferHits[0]);
          end
          8'h02: begin
            evDefined = 1'b1;
            evCount   = asCount(prefetchFillBufferHits[1]);
          end
          default: evDefined = 1'b0;
        endcase
      end
      EV_LINE_FILL: begin
        evDefined = (st_r.sel.unitMask == 8'h01);
        evCount   = asCount(firstLevelLineFillEvent);
      end
      EV_MOVE_ELIM: begin
        // Lines: 0 integer, 1 vector eliminated, 2 integer, 3 vector kept
        evDefined = 1'b1;
        case (st_r.sel.unitMask)
          8'h01: evCount = asCount(moveEliminationEvents[0]);
          8'h02: evCount = asCount(moveEliminationEvents[1]);
          8'h04: evCount = asCount(moveEliminationEvents[2]);
          8'h08: evCount = asCount(moveEliminationEvents[3]);
          default: evDefined = 1'b0;
        endcase
      end
      EV_RING: begin
        evDefined = 1'b1;
        case (st_r.sel.unitMask)
          8'h01: evCount = asCount(!threadHalted && privilegeRing == RING_ZERO);
          8'h02: evCount = asCount(!threadHalted && privilegeRing != RING_ZERO);
          default: evDefined = 1'b0;
        endcase
      end
      EV_SCHED_IDLE: begin
        evDefined = (st_r.sel.unitMask == 8'h01);
        evCount   = asCount(reservationStationEmpty);
      end
      EV_OFFCORE: begin
        // Counts are meaningless when threads share the queue
        evDefined = offcoreOk;
        case (st_r.sel.unitMask)
          8'h01: evCount = offcoreDataReads;
          8'h02: evCount = offcoreCodeReads;
          8'h04: evCount = offcoreOwnershipReads;
          default: evDefined = 1'b0;
        endcase
      end
      default: begin
        evDefined = 1'b0;
      end
    endcase
  end

  // Config and count into the qualifier
  assign step.eventCount = evDefined ? evCount : COUNT_ZERO;
  assign step.active     = evDefined && st_r.sel.enable;
  assign step.threshold  = st_r.sel.threshold;
  assign step.edgeMode   = st_r.sel.edgeMode;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  count_qualifier u_qualifier (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .link    (step.qualify)
  );

  assign countLoad = regWrite && (regAddr == ADDR_COUNT);

  count_accumulator u_accumulator (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (countLoad),
    .loadValue (regWrData),
    .link      (step.accum),
    .value     (accValue)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  // Live status bits
  always_comb begin
    statusWord               = '0;
    statusWord[STAT_DEFINED] = evDefined;
    statusWord[STAT_OFFCORE] = offcoreOk;
    statusWord[STAT_HALTED]  = threadHalted;
  end

  // Writes, read capture and registered outputs
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rdData = '0;
    if (regWrite && regAddr == ADDR_SELECT) begin
      st_nxt.sel = select_type'(regWrData & SELECT_WRITE_MASK); // Reserved stay zero
    end
    if (regRead) begin
      case (regAddr)
        ADDR_SELECT: st_nxt.rdData = word_type'(st_r.sel);
        ADDR_COUNT:  st_nxt.rdData = accValue;
        ADDR_STATUS: st_nxt.rdData = statusWord;
        default:     st_nxt.rdData = '0; // Unmapped reads zero
      endcase
    end
    st_nxt.counterOut = accValue;
    st_nxt.valid      = evDefined && st_r.sel.enable;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{sel: select_type'(SELECT_RESET), rdData: '0,
                counterOut: COUNT_RESET, valid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData      = st_r.rdData;
  assign counterValue   = st_r.counterOut;
  assign selectionValid = st_r.valid;

endmodule

/* File: bench/perf_event_select_decoder_properties.sv */
// Port-level assertions for the event-selection decoder
`timescale 1ns/1ps
module perf_event_select_decoder_properties (
  input wire logic                     sys_clk,
  input wire logic                     arst_n,
  input wire perf_event_pkg::byte_type regAddr,
  input wire perf_event_pkg::word_type regWrData,
  input wire logic                     regWrite,
  input wire logic                     regRead,
  input wire perf_event_pkg::word_type regRdData,
  input wire perf_event_pkg::word_type counterValue,
  input wire logic                     selectionValid
);
  import perf_event_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////
  // Read slot: data only in the cycle after the strobe
  rd_idle_a: assert property (!$past(regRead) |-> regRdData == 32'h0000_0000)
    else $error("read data outside its slot");
  unmapped_rd_a: assert property ($past(regRead) && $past(regAddr) > ADDR_STATUS
    |-> regRdData == 32'h0000_0000) else $error("unmapped read not zero");
  count_rd_a: assert property ($past(regRead) && $past(regAddr) == ADDR_COUNT
    |-> regRdData == counterValue) else $error("count read differs from view");
  sel_reserved_a: assert property ($past(regRead) && $past(regAddr) == ADDR_SELECT
    |-> regRdData[22:19] == 4'h0) else $error("reserved select bits set");
  status_rd_a: assert property ($past(regRead) && $past(regAddr) == ADDR_STATUS
    |-> regRdData[31:3] == 29'h0000_0000) else $error("status upper bits set");

  ////////////////////////////////////////////////////////////
  // Counter: a load lands two cycles on, nothing moves while invalid
  count_load_a: assert property (regWrite && regAddr == ADDR_COUNT
    |=> ##1 counterValue == $past(regWrData, 2)) else $error("count load lost");
  count_hold_a: assert property (
    !selectionValid && !$past(regWrite && regAddr == ADDR_COUNT)
    |=> $stable(counterValue)) else $error("count moved while invalid");
  undef_sel_a: assert property (
    regWrite && regAddr == ADDR_SELECT && (!regWrData[23] || regWrData[15:0] == 16'h0124)
    |=> ##1 !selectionValid) else $error("undefined pair marked valid");
  defined_sel_a: assert property (
    regWrite && regAddr == ADDR_SELECT && regWrData == 32'h0080_FF24
    |=> ##1 selectionValid) else $error("defined pair marked invalid");

  // Main scenarios reached
  cover property (selectionValid && $changed(counterValue));
  cover property (regWrite && regAddr == ADDR_COUNT);
  cover property (regRead && regAddr == ADDR_STATUS);
endmodule

bind perf_event_select_decoder perf_event_select_decoder_properties chk (
  .sys_clk, .arst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
  .counterValue, .selectionValid);

/* File: bench/tb.sv */
// Self-checking bench for the event-selection decoder
`timescale 1ns/1ps
module tb;
  import perf_event_pkg::*;
  typedef struct packed {
    logic [7:0] l2;
    logic       wb, llRef, llMiss, halt, tick;
    count_type  pend;
    logic [7:0] st;
    logic [1:0] pf;
    logic       fill;
    logic [3:0] mv;
    logic [1:0] ring;
    logic       empty;
    count_type  dat, code, own;
    logic       mt;
  } ev_type;
  logic     sys_clk = 1'b0;
  logic     arst_n = 1'b0;
  byte_type regAddr = 8'h00;
  word_type regWrData = 32'h0000_0000;
  logic     regWrite = 1'b0;
  logic     regRead = 1'b0;
  word_type regRdData, counterValue;
  logic     selectionValid;
  ev_type   ev = '0;
  ev_type   z = '0;
  int       mismatches = 0;
  int       cmpCount = 0;
  int       cycles = 0;

  // 40 MHz core clock
  always #12.5 sys_clk = ~sys_clk;

  perf_event_select_decoder dut (
    .sys_clk, .arst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .secondLevelRequestEvents(ev.l2), .writebackHitEvent(ev.wb),
    .lastLevelRefEvent(ev.llRef), .lastLevelMissEvent(ev.llMiss),
    .threadHalted(ev.halt), .referenceClock100mTick(ev.tick),
    .pendingFirstLevelMisses(ev.pend), .storeTranslationMissEvents(ev.st),
    .prefetchFillBufferHits(ev.pf), .firstLevelLineFillEvent(ev.fill),
    .moveEliminationEvents(ev.mv), .privilegeRing(ev.ring),
    .reservationStationEmpty(ev.empty), .offcoreDataReads(ev.dat),
    .offcoreCodeReads(ev.code), .offcoreOwnershipReads(ev.own),
    .multithreading(ev.mt), .counterValue, .selectionValid);

  ////////////////////////////////////////////////////////////
  task automatic testDone;
    $display("compares %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string n, word_type x, word_type g);
    cmpCount++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask

  // Strobes start after an edge, so back-to-back calls never overlap
  task automatic wr(byte_type a, word_type d);
    @(posedge sys_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(byte_type a, word_type x, string n);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    chk(n, x, regRdData);
    // Return on a rising edge so callers drive inputs there
    @(posedge sys_clk);
  endtask

  function automatic word_type sel(byte_type c, m, logic [1:0] i = 2'h0,
                                   logic e = 1'b0, byte_type t = 8'h00);
    return {t, 1'b1, 4'h0, e, i, m, c};
  endfunction

  // Idle inputs must not count, so window edges never add stray steps
  task automatic run(word_type s, ev_type i, ev_type a, int k, bit alt, word_type x);
    ev <= i;
    wr(ADDR_COUNT, 32'h0000_0000);
    wr(ADDR_SELECT, s);
    for (int j = 0; j < k; j++) begin
      ev <= (alt && j % 2) ? i : a;
      @(posedge sys_clk);
    end
    ev <= i;
    wr(ADDR_SELECT, 32'h0000_0000);
    rd(ADDR_COUNT, x, "count");
  endtask

  // Each mask against each source line alone
  task automatic sweep(byte_type c, byte_type m[9], byte_type g[9], int base);
    for (int p = 0; p < 9; p++)
      for (int b = 0; b < 8; b++)
        run(sel(c, m[p]), z, ev_type'(48'h1 << (base + b)), 3, 1'b0, g[p][b] ? 3 : 0);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic regMap;
    ev_type e;
    e = z;
    e.mt = 1'b1;
    rd(ADDR_SELECT, 32'h0000_0000, "select");
    rd(ADDR_STATUS, 32'h0000_0002, "status");
    wr(ADDR_SELECT, 32'hFFFF_FFFF);
    rd(ADDR_SELECT, 32'hFF87_FFFF, "select");
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, 32'h0000_0002, "status");
    wr(ADDR_COUNT, 32'h1234_5678);
    rd(ADDR_COUNT, 32'h1234_5678, "count");
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, "unmapped");
    wr(ADDR_SELECT, sel(8'h24, 8'hFF));
    rd(ADDR_STATUS, 32'h0000_0003, "status");
    ev <= e;
    wr(ADDR_SELECT, sel(8'h60, 8'h01));
    rd(ADDR_STATUS, 32'h0000_0000, "status");
  endtask

  task automatic groups;
    byte_type m[9] = '{8'h24, 8'h27, 8'hE7, 8'hE4, 8'h50, 8'h30, 8'hF8, 8'h3F, 8'hFF};
    byte_type g[9] = '{8'h10, 8'h15, 8'h3F, 8'h30, 8'h80, 8'h40, 8'hC0, 8'h55, 8'hFF};
    byte_type s[9] = '{8'h01, 8'h02, 8'h04, 8'h0E, 8'h10, 8'h20, 8'h40, 8'h60, 8'h80};
    sweep(8'h24, m, g, 40);
    sweep(8'h49, s, s, 23);
  endtask

  task automatic singles;
    byte_type c[11] = '{8'h27, 8'h2E, 8'h2E, 8'h4C, 8'h4C, 8'h51, 8'h58, 8'h58, 8'h58,
                        8'h58, 8'h5E};
    byte_type m[11] = '{8'h50, 8'h4F, 8'h41, 8'h01, 8'h02, 8'h01, 8'h01, 8'h02, 8'h04,
                        8'h08, 8'h01};
    int p[11] = '{39, 38, 37, 21, 22, 20, 16, 17, 18, 19, 13};
    for (int i = 0; i < 11; i++)
      run(sel(c[i], m[i]), z, ev_type'(48'h1 << p[i]), 3, 1'b0, 3);
  endtask

  task automatic cycleEvents;
    ev_type h, t, ht;
    h = z;
    h.halt = 1'b1;
    t = z;
    t.tick = 1'b1;
    ht = h;
    ht.tick = 1'b1;
    run(sel(8'h3C, 8'h00), h, z, 4, 1'b0, 4);
    run(sel(8'h3C, 8'h00), h, h, 4, 1'b0, 0);
    run(sel(8'h3C, 8'h01), h, t, 4, 1'b1, 2);
    run(sel(8'h3C, 8'h01), h, z, 4, 1'b0, 0);
    run(sel(8'h3C, 8'h01), h, ht, 4, 1'b0, 0);
  endtask

  task automatic pendMisses;
    ev_type a;
    a = z;
    a.pend = 4'h5;
    run(sel(8'h48, 8'h01, 2'h2), z, a, 4, 1'b0, 20);
    run(sel(8'h48, 8'h01), z, a, 4, 1'b0, 0);
    run(sel(8'h48, 8'h01, 2'h2, 1'b0, 8'h05), z, a, 4, 1'b0, 4);
    run(sel(8'h48, 8'h01, 2'h2, 1'b0, 8'h06), z, a, 4, 1'b0, 0);
    run(sel(8'h48, 8'h01, 2'h2, 1'b1, 8'h01), z, a, 5, 1'b1, 3);
    run(sel(8'h48, 8'h01, 2'h2, 1'b1, 8'h01), z, a, 5, 1'b0, 1);
  endtask

  task automatic ringCycles;
    ev_type r, rh;
    r = z;
    r.ring = 2'h1;
    rh = r;
    rh.halt = 1'b1;
    run(sel(8'h5C, 8'h01), r, z, 3, 1'b0, 3);
    run(sel(8'h5C, 8'h02), z, r, 3, 1'b0, 3);
    run(sel(8'h5C, 8'h02), z, rh, 3, 1'b0, 0);
    run(sel(8'h5C, 8'h01, 2'h0, 1'b1, 8'h01), r, z, 5, 1'b1, 3);
  endtask

  task automatic offcore;
    ev_type a, m;
    a = z;
    a.dat = 4'h3;
    a.code = 4'h2;
    a.own = 4'h7;
    m = a;
    m.mt = 1'b1;
    run(sel(8'h60, 8'h01), z, a, 4, 1'b0, 12);
    run(sel(8'h60, 8'h02), z, a, 4, 1'b0, 8);
    run(sel(8'h60, 8'h04), z, a, 4, 1'b0, 28);
    run(sel(8'h60, 8'h01, 2'h0, 1'b0, 8'h01), z, a, 4, 1'b0, 4);
    run(sel(8'h60, 8'h01), z, m, 4, 1'b0, 0);
  endtask

  task automatic undefined;
    ev_type a;
    a = '1;
    a.halt = 1'b0;
    run(sel(8'h24, 8'h01), z, a, 3, 1'b0, 0);
    run(sel(8'h00, 8'h00), z, a, 3, 1'b0, 0);
    run(sel(8'h3C, 8'h02), z, a, 3, 1'b0, 0);
    run(sel(8'h24, 8'hFF) & 32'hFF7F_FFFF, z, a, 3, 1'b0, 0);
  endtask

  ////////////////////////////////////////////////////////////
  // Hang guard, well above the few thousand cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      testDone();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    regMap();
    groups();
    singles();
    cycleEvents();
    pendMisses();
    ringCycles();
    offcore();
    undefined();
    testDone();
  end
endmodule
